// ### src/bfs_supervisor.v
// Top level of the four channel buck fault supervisor
//
// Function
// - Power good low on under/overvoltage of channels two to four.
// - Always-on channel never affects power good.
// - Channels one to three held off while their supply lockout asserts.
// - Low thermal trip latches load switches off, bucks keep running.
// - Low thermal latch clears when load switch enable goes low.
// - High thermal trip latches switches and channels 2-4 off.
// - High thermal latch clears on 15 low enable counts or power cycle.
// - Overcurrent ends the on-pulse; next oscillator tick resumes.
// - Overcurrent ignored during leading edge blanking.
// - Hiccup counter enabled only above soft-start enable level.
// - Count limit 30 with low feedback, else 118.
// - Limit reached sets hiccup latch, pulls compensation, enables sink.
// - Soft start at reset level clears latch, enables source.
// - Switching resumes above ramp offset; hiccups repeat while short.
// - Hiccup after 7 missing-boot or 30 shorted-boot PWM cycles.
// - Boot faults not latched; recovery is automatic.
// - Diode fault: channel one hiccups, channels two to four latch.
// - Diode latch cleared by enable low or supply power cycle.
// - Feedback overvoltage stops switching on any channel.
// - Overvoltage on channels two to four pulls power good low.
// - Overvoltage shutdown is not latched.
// - Channel one enters low quiescent mode 2048 cycles after high trip.
`timescale 1ns/1ps
`default_nettype none
`include "bfs_map.vh"
module bfs_supervisor (
	input wire sys_clk,
	input wire reset_n,
	input wire pwm_tick,
	input wire ensync_in,
	input wire load_switch_enable,
	input wire first_supply_por,
	input wire thermal_low_trip,
	input wire thermal_high_trip,
	input wire [2:0] supply_lockout,
	input wire [3:0] fb_under,
	input wire [3:0] fb_over,
	input wire [3:0] fb_low,
	input wire [3:0] over_current,
	input wire [3:0] ss_above_enable,
	input wire [3:0] ss_below_reset,
	input wire [3:0] ss_above_offset,
	input wire [3:0] boot_missing,
	input wire [3:0] boot_short,
	input wire [3:0] switch_negative,
	output reg [3:0] gate_on,
	output reg [3:0] comp_pull_down,
	output reg [3:0] soft_start_sink,
	output reg [3:0] soft_start_source,
	output reg power_good_out,
	output reg power_good_oe_n,
	output reg load_switch_a,
	output reg load_switch_b,
	output reg low_quiescent_mode
);
	// ==========================================================
	// Reset release and input synchronisers
	// ==========================================================
	// Every comparator and pin input below crosses into the clock domain.
	// Comparators switch on analog edges that bear no relation to sys_clk,
	// so each bit gets its own three-stage chain. A bit is taken as changed
	// only once stages two and three agree, which also rejects a single
	// metastable or glitchy sample that resolves the wrong way.
	// All inputs but pwm_tick and reset_n are packed into one vector so that the chains
	// are written once; the slices further down unpack it again.
	reg [1:0] rst_pipe;
	wire rst_n;
	// Five single bits, ten four-bit groups and the three lockout bits
	localparam NIN = 48;
	wire [NIN-1:0] raw_in;
	reg [NIN-1:0] s1;
	reg [NIN-1:0] s2;
	reg [NIN-1:0] s3;
	reg [NIN-1:0] clean;
	reg [3:0] tick_pipe;

	// Reset released through two flops
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	assign raw_in = {ensync_in, load_switch_enable, first_supply_por,
		thermal_low_trip, thermal_high_trip, fb_under, fb_over, fb_low,
		over_current, ss_above_enable, ss_below_reset, ss_above_offset,
		boot_missing, boot_short, switch_negative, supply_lockout};

	// Three-flop synchronisers; change accepted when stages two and three agree
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= {NIN{1'b0}};
			s2 <= {NIN{1'b0}};
			s3 <= {NIN{1'b0}};
			clean <= {NIN{1'b0}};
			tick_pipe <= 4'h0;
		end else begin
			s1 <= raw_in;
			s2 <= s1;
			s3 <= s2;
			clean <= (s2 & s3) | (clean & (s2 | s3));
			tick_pipe <= {tick_pipe[2:0], pwm_tick};
		end
	end

	// ==========================================================
	// Filtered input slices
	// ==========================================================
	// Slice positions follow the packing order of raw_in, MSB first.
	// Any new input must be added to both places, and NIN widened.
	// Enable/sync level, low counts toward the latch clear
	wire ens_q = clean[47];
	// Load switch enable, low also clears the low thermal latch
	wire lse_q = clean[46];
	// First supply power cycle, clears the thermal and diode latches
	wire por_q = clean[45];
	// Thermal trip levels
	wire tl_q = clean[44];
	wire th_q = clean[43];
	// Feedback window and low-feedback comparators
	wire [3:0] fbu_q = clean[42:39];
	wire [3:0] fbo_q = clean[38:35];
	wire [3:0] fbl_q = clean[34:31];
	// Cycle current limit comparators
	wire [3:0] oc_q = clean[30:27];
	// Soft-start level comparators
	wire [3:0] sse_q = clean[26:23];
	wire [3:0] ssr_q = clean[22:19];
	wire [3:0] sso_q = clean[18:15];
	// Boot capacitor and switch node fault comparators
	wire [3:0] bm_q = clean[14:11];
	wire [3:0] boot_short_q = clean[10:7];
	wire [3:0] sn_q = clean[6:3];
	// Supply lockout for channels one to three sits in clean[2:0]
	// Hazard: a comparator chattering near its threshold still passes
	// through, only delayed; hysteresis must come from the analog side.
	// ==========================================================
	// Thermal and enable/sync latches
	// ==========================================================
	// The oscillator pulse is used by its rising edge only, so a long
	// pulse still counts as one PWM cycle everywhere downstream.
	wire tick = tick_pipe[2] & ~tick_pipe[3];
	reg [3:0] ens_low_count;
	reg ens_cleared;
	reg thermal_low_latch;
	reg thermal_high_latch;
	reg [11:0] lowq_count;
	wire clear_latch = ens_cleared || por_q;

	// Enable/sync low counted in PWM clocks
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ens_low_count <= 4'h0;
			ens_cleared <= 1'b0;
		end else begin
			if (ens_q)
				ens_low_count <= 4'h0;
			else if (tick && ens_low_count != `BFS_ENSYNC_LOW_COUNT)
				ens_low_count <= ens_low_count + 4'd1;
			ens_cleared <= (ens_low_count == `BFS_ENSYNC_LOW_COUNT);
		end
	end

	// Thermal latches; a trip wins over a clear
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			thermal_low_latch <= 1'b0;
			thermal_high_latch <= 1'b0;
			lowq_count <= 12'h000;
		end else begin
			if (tl_q && !th_q)
				thermal_low_latch <= 1'b1;
			else if (!lse_q || clear_latch)
				thermal_low_latch <= 1'b0;
			if (th_q)
				thermal_high_latch <= 1'b1;
			else if (clear_latch)
				thermal_high_latch <= 1'b0;
			if (!thermal_high_latch)
				lowq_count <= 12'h000;
			else if (tick && lowq_count != `BFS_LOWQ_DELAY_COUNT)
				lowq_count <= lowq_count + 12'd1;
		end
	end
	// ==========================================================
	// Channel instances
	// ==========================================================
	wire [3:0] ch_en;
	wire [3:0] ch_gate;
	wire [3:0] ch_comp;
	wire [3:0] ch_sink;
	wire [3:0] ch_src;
	wire [3:0] ch_diode;

	// Lockout on channels one to three, thermal off on two to four.
	// The always-on channel is never switched off by temperature; it
	// only drops into its low quiescent mode after the delay count.
	// Channel four has no supply lockout comparator of its own.
	assign ch_en[0] = !clean[0];
	assign ch_en[1] = !clean[1] && !thermal_high_latch;
	assign ch_en[2] = !clean[2] && !thermal_high_latch;
	assign ch_en[3] = !thermal_high_latch;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
			bfs_channel #(
				.DIODE_LATCH(gi == 0 ? 0 : 1)
			) u_ch (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.enable(ch_en[gi]),
				.pwm_tick(tick),
				.over_current(oc_q[gi]),
				.fb_low(fbl_q[gi]),
				.fb_over(fbo_q[gi]),
				.ss_above_enable(sse_q[gi]),
				.ss_below_reset(ssr_q[gi]),
				.ss_above_offset(sso_q[gi]),
				.boot_missing(bm_q[gi]),
				.boot_short(boot_short_q[gi]),
				.switch_negative(sn_q[gi]),
				.clear_latch(clear_latch),
				.gate_on(ch_gate[gi]),
				.comp_pull_down(ch_comp[gi]),
				.ss_sink(ch_sink[gi]),
				.ss_source(ch_src[gi]),
				.diode_latched(ch_diode[gi])
			);
		end
	endgenerate
	// ==========================================================
	// Registered outputs
	// ==========================================================
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_on <= 4'h0;
			comp_pull_down <= 4'h0;
			soft_start_sink <= 4'h0;
			soft_start_source <= 4'h0;
			power_good_out <= 1'b0;
			power_good_oe_n <= 1'b0;
			load_switch_a <= 1'b0;
			load_switch_b <= 1'b0;
			low_quiescent_mode <= 1'b0;
		end else begin
			gate_on <= ch_gate;
			comp_pull_down <= ch_comp | {{3{thermal_high_latch}}, 1'b0};
			soft_start_sink <= ch_sink | {{3{thermal_high_latch}}, 1'b0};
			soft_start_source <= ch_src & ~{{3{thermal_high_latch}}, 1'b0};
			// Only channels two to four can pull power good low.
			// The data bit stays low; the enable decides whether the
			// open-drain pin pulls down or is left to its pull-up.
			power_good_out <= 1'b0;
			power_good_oe_n <= !(|fbu_q[3:1] || |fbo_q[3:1]);
			load_switch_a <= lse_q && !thermal_low_latch &&
				!thermal_high_latch;
			load_switch_b <= lse_q && !thermal_low_latch &&
				!thermal_high_latch;
			low_quiescent_mode <= (lowq_count == `BFS_LOWQ_DELAY_COUNT);
		end
	end
endmodule // bfs_supervisor
`default_nettype wire

// ### src/bfs_map.vh
// Constants shared by the buck fault supervisor design
`ifndef BFS_MAP_VH
`define BFS_MAP_VH
// Overcurrent count limits: low feedback and normal feedback
`define BFS_OCP_LIMIT_LOW 7'd30
`define BFS_OCP_LIMIT_HIGH 7'd118
// Boot capacitor fault qualification counts
`define BFS_BOOT_MISSING_COUNT 7'd7
`define BFS_BOOT_SHORT_COUNT 7'd30
// Enable/sync low qualification in PWM clock counts
`define BFS_ENSYNC_LOW_COUNT 4'd15
// Always-on channel run time after high thermal trip, PWM cycles
`define BFS_LOWQ_DELAY_COUNT 12'd2048
// Leading edge blanking in system clock cycles
`define BFS_BLANK_CYCLES 3'd2
// Diode fault qualification in clock cycles
`define BFS_DIODE_QUAL_CYCLES 2'd1
// Hiccup state encoding
`define BFS_ST_RUN 2'd0
`define BFS_ST_HICCUP 2'd1
`define BFS_ST_RAMP 2'd2
`endif

// ### src/bfs_channel.v
// One buck channel: overcurrent, hiccup, boot and diode fault handling
`timescale 1ns/1ps
`default_nettype none
`include "bfs_map.vh"
module bfs_channel #(
	parameter DIODE_LATCH = 1
) (
	input wire sys_clk,
	input wire rst_n,
	input wire enable,
	input wire pwm_tick,
	input wire over_current,
	input wire fb_low,
	input wire fb_over,
	input wire ss_above_enable,
	input wire ss_below_reset,
	input wire ss_above_offset,
	input wire boot_missing,
	input wire boot_short,
	input wire switch_negative,
	input wire clear_latch,
	output reg gate_on,
	output reg comp_pull_down,
	output reg ss_sink,
	output reg ss_source,
	output reg diode_latched
);
	reg [1:0] state;
	reg [1:0] next_state;
	reg [6:0] ocp_count;
	reg [6:0] boot_miss_count;
	reg [6:0] boot_short_count;
	reg [2:0] blank_count;
	reg [1:0] neg_count;
	reg on_pulse;
	wire [6:0] ocp_limit;
	wire ocp_hit;
	wire boot_trip;
	wire diode_event;
	wire hic_trip;
	wire stop_switch;

	// Count limit depends on feedback level
	assign ocp_limit = fb_low ? `BFS_OCP_LIMIT_LOW : `BFS_OCP_LIMIT_HIGH;
	// Current limit counts only after blanking
	assign ocp_hit = on_pulse && over_current && (blank_count == 3'd0);
	assign boot_trip = (boot_miss_count >= `BFS_BOOT_MISSING_COUNT) ||
		(boot_short_count >= `BFS_BOOT_SHORT_COUNT);
	assign diode_event = (neg_count > `BFS_DIODE_QUAL_CYCLES);
	assign hic_trip = (ss_above_enable && (ocp_count >= ocp_limit)) ||
		boot_trip || (diode_event && !DIODE_LATCH);
	// Overvoltage stops switching without latching
	assign stop_switch = fb_over || !enable || diode_latched;

	// Hiccup state sequencing
	always @* begin
		next_state = state;
		case (state)
			`BFS_ST_RUN: begin
				if (hic_trip)
					next_state = `BFS_ST_HICCUP;
			end
			`BFS_ST_HICCUP: begin
				if (ss_below_reset)
					next_state = `BFS_ST_RAMP;
			end
			`BFS_ST_RAMP: begin
				if (ss_above_offset)
					next_state = `BFS_ST_RUN;
			end
			default: next_state = `BFS_ST_RUN;
		endcase
	end

	// State, counters and outputs
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= `BFS_ST_RAMP;
			ocp_count <= 7'h00;
			boot_miss_count <= 7'h00;
			boot_short_count <= 7'h00;
			blank_count <= 3'h0;
			neg_count <= 2'h0;
			on_pulse <= 1'b0;
			gate_on <= 1'b0;
			comp_pull_down <= 1'b0;
			ss_sink <= 1'b0;
			ss_source <= 1'b0;
			diode_latched <= 1'b0;
		end else begin
			state <= enable ? next_state : `BFS_ST_RAMP;
			// Diode latch cleared by enable low or supply cycle
			if (DIODE_LATCH && diode_event)
				diode_latched <= 1'b1;
			else if (clear_latch)
				diode_latched <= 1'b0;
			// Negative switch node qualification
			if (switch_negative && neg_count != 2'h3)
				neg_count <= neg_count + 2'd1;
			else if (!switch_negative)
				neg_count <= 2'h0;
			// Counter cleared on disable, low soft start or outside the run state
			if (!enable || !ss_above_enable || state != `BFS_ST_RUN)
				ocp_count <= 7'h00;
			else if (ocp_hit && ocp_count != 7'h7F)
				ocp_count <= ocp_count + 7'd1;
			// Boot faults counted per PWM cycle, never latched
			if (!enable || state != `BFS_ST_RUN) begin
				boot_miss_count <= 7'h00;
				boot_short_count <= 7'h00;
			end else if (pwm_tick) begin
				boot_miss_count <= boot_missing ?
					boot_miss_count + 7'd1 : 7'h00;
				boot_short_count <= boot_short ?
					boot_short_count + 7'd1 : 7'h00;
			end
			// On-pulse starts on tick, ends on limit
			if (stop_switch || state != `BFS_ST_RUN) begin
				on_pulse <= 1'b0;
				blank_count <= 3'h0;
			end else if (pwm_tick) begin
				on_pulse <= 1'b1;
				blank_count <= `BFS_BLANK_CYCLES;
			end else begin
				if (ocp_hit)
					on_pulse <= 1'b0;
				if (blank_count != 3'h0)
					blank_count <= blank_count - 3'd1;
			end
			gate_on <= on_pulse && !stop_switch && !ocp_hit &&
				state == `BFS_ST_RUN;
			comp_pull_down <= (state == `BFS_ST_HICCUP) || diode_latched;
			ss_sink <= (state == `BFS_ST_HICCUP) || diode_latched;
			ss_source <= enable && !diode_latched &&
				state != `BFS_ST_HICCUP;
		end
	end
endmodule // bfs_channel
`default_nettype wire

// ### tb/bfs_ss_model.sv
// Soft-start node model with its three level comparators per channel
`timescale 1ns/1ps
`default_nettype none
module bfs_ss_model (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic [3:0] sink,
	input wire logic [3:0] source,
	output wire logic [3:0] above_enable,
	output wire logic [3:0] below_reset,
	output wire logic [3:0] above_offset
);
	// ====================
	// Ramp generators
	logic phase = 1'b0;
	// Slow mode moves the level on every other clock only
	always @(posedge sys_clk) phase <= ~phase;
	for (genvar g = 0; g < 4; g++) begin : g_ch
		logic [8:0] level = 9'h000;
		// The sink discharges the node, the source charges it
		always @(posedge sys_clk) begin
			if (!slow || phase) begin
				if (sink[g] && level != 9'h000) level <= level - 9'h001;
				else if (source[g] && level != 9'h12C) level <= level + 9'h001;
			end
		end
		assign above_enable[g] = level > 9'h0E6;
		assign below_reset[g] = level < 9'h014;
		assign above_offset[g] = level > 9'h028;
	end
endmodule // bfs_ss_model
`default_nettype wire

// ### tb/bfs_supervisor_checker.sv
// Port-level assertions for the buck fault supervisor
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic thermal_low_trip,
	input wire logic thermal_high_trip,
	input wire logic [2:0] supply_lockout,
	input wire logic [3:0] fb_under,
	input wire logic [3:0] fb_over,
	input wire logic [3:0] ss_below_reset,
	input wire logic [3:0] gate_on,
	input wire logic [3:0] comp_pull_down,
	input wire logic [3:0] soft_start_sink,
	input wire logic [3:0] soft_start_source,
	input wire logic power_good_oe_n,
	input wire logic load_switch_a,
	input wire logic load_switch_b
);
	// ====================
	// Helpers
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	logic [4:0] up;
	wire logic pg_fault = |fb_under[3:1] || |fb_over[3:1];
	// Cycles since reset, so the start-up pull-down is not judged
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) up <= 5'h00;
		else if (up != 5'h1F) up <= up + 5'h01;
	end
	sequence s_sink_on;
		$rose(soft_start_sink[1]);
	endsequence
	sequence s_ss_floor;
		ss_below_reset[0] [*8];
	endsequence
	// ====================
	// Properties
	AST_PG_FAULT: assert property (pg_fault [*8] |-> !power_good_oe_n)
		else $error("power good not pulled low");
	AST_PG_CLEAN: assert property (
		(up == 5'h1F && !pg_fault) [*8] |-> power_good_oe_n)
		else $error("power good pulled low without cause");
	AST_LOCKOUT: assert property (supply_lockout[0] [*8] |-> !gate_on[0])
		else $error("channel switching in lockout");
	AST_TLOW: assert property (
		thermal_low_trip [*8] |-> !load_switch_a && !load_switch_b)
		else $error("load switches on during low trip");
	AST_THIGH: assert property (
		thermal_high_trip [*8] |-> gate_on[3:1] == 3'h0 && !load_switch_b)
		else $error("outputs on during high trip");
	AST_OVP: assert property (fb_over[2] [*8] |-> !gate_on[2])
		else $error("switching during overvoltage");
	AST_SINK_SET: assert property (
		s_sink_on |-> comp_pull_down[1] && !soft_start_source[1])
		else $error("hiccup sink without pull-down");
	AST_SINK_CLR: assert property (s_ss_floor |-> !soft_start_sink[0])
		else $error("sink kept at reset level");
endmodule // bfs_supervisor_checker
bind bfs_supervisor bfs_supervisor_checker i_bfs_supervisor_checker (
	.sys_clk, .reset_n, .thermal_low_trip, .thermal_high_trip,
	.supply_lockout, .fb_under, .fb_over, .ss_below_reset, .gate_on,
	.comp_pull_down, .soft_start_sink, .soft_start_source,
	.power_good_oe_n, .load_switch_a, .load_switch_b);
`default_nettype wire

// ### tb/bfs_supervisor_bench.sv
// Self-checking bench for the buck fault supervisor
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor_bench;
	logic sys_clk = 1'b0, reset_n = 1'b0, pwm_tick = 1'b0, slow = 1'b0;
	logic ensync_in = 1'b1, load_switch_enable = 1'b1, first_supply_por = 1'b0;
	logic thermal_low_trip = 1'b0, thermal_high_trip = 1'b0;
	logic [2:0] supply_lockout = 3'h0;
	logic [3:0] fb_under = 4'h0, fb_over = 4'h0, fb_low = 4'h0;
	logic [3:0] over_current = 4'h0, boot_missing = 4'h0, boot_short = 4'h0;
	logic [3:0] switch_negative = 4'h0;
	wire [3:0] sse, ssr, sso, gate_on, comp_pull_down, sink, source;
	wire power_good_out, power_good_oe_n, load_switch_a, load_switch_b;
	wire low_quiescent_mode;
	int num_errors = 0, n_compared = 0, t = 0;
	// ====================
	// Clock, oscillator tick and instances
	always #2.5 sys_clk = ~sys_clk;
	// One PWM tick every 20 clocks
	always @(posedge sys_clk) begin
		#1 t <= (t == 19) ? 0 : t + 1;
		pwm_tick <= (t == 19);
	end
	bfs_supervisor i_bfs_supervisor (.sys_clk, .reset_n, .pwm_tick,
		.ensync_in, .load_switch_enable, .first_supply_por,
		.thermal_low_trip, .thermal_high_trip, .supply_lockout, .fb_under,
		.fb_over, .fb_low, .over_current, .ss_above_enable(sse),
		.ss_below_reset(ssr), .ss_above_offset(sso), .boot_missing,
		.boot_short, .switch_negative, .gate_on, .comp_pull_down,
		.soft_start_sink(sink), .soft_start_source(source), .power_good_out,
		.power_good_oe_n, .load_switch_a, .load_switch_b, .low_quiescent_mode);
	bfs_ss_model i_bfs_ss_model (.sys_clk, .slow, .sink, .source,
		.above_enable(sse), .below_reset(ssr), .above_offset(sso));
	// ====================
	// Tasks
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task ticks(input int n);
		repeat (n) @(posedge pwm_tick);
		cyc(1);
	endtask
	task chk(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wait_src(input int ch);
		for (int i = 0; i < 3000 && source[ch] !== 1'b1; i++) cyc(1);
	endtask
	// Over-current after blanking on channel two, gate seen on then off
	task oc_pulse(input int n);
		repeat (n) begin
			ticks(1);
			cyc(7);
			chk(gate_on[1], 1'b1);
			over_current[1] = 1'b1;
			cyc(4);
			over_current[1] = 1'b0;
			cyc(4);
			chk(gate_on[1], 1'b0);
		end
	endtask
	task tally_and_finish;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		#450000;
		num_errors++;
		tally_and_finish;
	end
	// ====================
	// Test sequence
	initial begin
		cyc(20);
		reset_n = 1'b1;
		cyc(600);
		for (int i = 0; i < 4; i++) begin
			fb_under[i] = 1'b1;
			cyc(10);
			chk(power_good_oe_n, i == 0);
			fb_under[i] = 1'b0;
			fb_over[i] = 1'b1;
			cyc(10);
			chk(power_good_oe_n, i == 0);
			chk(gate_on[i], 1'b0);
			fb_over[i] = 1'b0;
			cyc(60);
			chk(gate_on[i], 1'b1);
		end
		supply_lockout = 3'h7;
		cyc(10);
		chk(gate_on, 4'h8);
		supply_lockout = 3'h0;
		cyc(100);
		thermal_low_trip = 1'b1;
		cyc(10);
		thermal_low_trip = 1'b0;
		cyc(10);
		chk({load_switch_a, load_switch_b, gate_on[1:0]}, 4'h3);
		load_switch_enable = 1'b0;
		cyc(10);
		load_switch_enable = 1'b1;
		cyc(10);
		chk({load_switch_a, load_switch_b}, 2'h3);
		thermal_high_trip = 1'b1;
		cyc(10);
		thermal_high_trip = 1'b0;
		chk({gate_on[3:1], load_switch_a}, 4'h0);
		ticks(2040);
		chk(low_quiescent_mode, 1'b0);
		ticks(16);
		chk(low_quiescent_mode, 1'b1);
		ensync_in = 1'b0;
		ticks(12);
		ensync_in = 1'b1;
		cyc(10);
		chk(gate_on[3:1], 3'h0);
		ensync_in = 1'b0;
		ticks(17);
		ensync_in = 1'b1;
		cyc(600);
		chk({low_quiescent_mode, gate_on[3:1]}, 4'h7);
		for (int k = 0; k < 2; k++) begin
			fb_low[1] = (k == 0);
			slow = (k == 1);
			oc_pulse(k ? 117 : 29);
			cyc(10);
			chk(sink[1], 1'b0);
			oc_pulse(1);
			cyc(4);
			chk({sink[1], comp_pull_down[1], source[1]}, 3'h6);
			wait_src(1);
			chk({sink[1], source[1]}, 2'h1);
			cyc(900);
		end
		for (int k = 0; k < 2; k++) begin
			ticks(1);
			boot_missing[2] = (k == 0);
			boot_short[2] = (k == 1);
			ticks(k ? 29 : 6);
			cyc(8);
			chk(sink[2], 1'b0);
			ticks(1);
			cyc(8);
			chk(sink[2], 1'b1);
			boot_missing[2] = 1'b0;
			boot_short[2] = 1'b0;
			wait_src(2);
			cyc(600);
			chk({sink[2], gate_on[2]}, 2'h1);
		end
		switch_negative = 4'h9;
		cyc(4);
		switch_negative = 4'h0;
		cyc(10);
		chk({gate_on[3], sink[0]}, 2'h1);
		ticks(3);
		chk(gate_on[3], 1'b0);
		first_supply_por = 1'b1;
		cyc(4);
		first_supply_por = 1'b0;
		wait_src(0);
		cyc(600);
		chk({gate_on[3], gate_on[0]}, 2'h3);
		tally_and_finish;
	end
endmodule // bfs_supervisor_bench
`default_nettype wire
